// [rtl/mgr_map.vh]
// Constants shared by the PHY-side framing logic.
`ifndef MGR_MAP_VH
`define MGR_MAP_VH

// Data path widths.
`define MGR_BYTE_W 8
`define MGR_NIB_W 4
`define MGR_RXERR_W 6

// Field positions.
`define MGR_RXERR_PHY_BIT 0
`define MGR_LOW_NIB_LSB 0
`define MGR_UP_NIB_LSB 4

// Synchroniser width: link clock, valid, error and one byte.
`define MGR_RX_SYNC_W 11

// Reset values.
`define MGR_BYTE_RST 8'h00
`define MGR_NIB_RST 4'h0
`define MGR_RXERR_RST 6'h00

`endif

// [rtl/mgr_phy_side.v]
// PHY-side framing of a gigabit MAC: transmit over the gigabit and reduced gigabit interfaces, receive over the gigabit interface.
`timescale 1ns/100ps
`default_nettype none
`include "mgr_map.vh"

module mgr_phy_side (
  input wire clk_i,
  input wire arst_n_i,
  input wire gig_tx_clk_i,
  input wire client_tx_valid_i,
  input wire [`MGR_BYTE_W-1:0] client_tx_data_i,
  input wire client_tx_end_of_packet_i,
  input wire client_tx_error_flag_i,
  output reg client_tx_ready_o,
  output reg [`MGR_BYTE_W-1:0] gig_tx_byte_bus_o,
  output reg gig_tx_frame_enable_o,
  output reg gig_tx_error_out_o,
  output reg [`MGR_NIB_W-1:0] rgmii_tx_nibble_o,
  output reg rgmii_tx_control_o,
  input wire gig_rx_clk_i,
  input wire gig_rx_data_valid_i,
  input wire gig_rx_error_in_i,
  input wire [`MGR_BYTE_W-1:0] gig_rx_byte_bus_i,
  output reg client_rx_valid_o,
  output reg [`MGR_BYTE_W-1:0] client_rx_data_o,
  output reg client_rx_sop_o,
  output reg client_rx_eop_o,
  output reg [`MGR_RXERR_W-1:0] client_rx_error_o
);

  localparam RX_IDLE = 2'b01;
  localparam RX_FRAME = 2'b10;

  function edge_seen;
    input now_level;
    input last_level;
    begin
      edge_seen = now_level & ~last_level;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link clock sampling.

  wire tx_clk_sync;
  reg tx_clk_last_reg;
  wire [`MGR_RX_SYNC_W-1:0] rx_sync;
  reg rx_clk_last_reg;

  mgr_sync #(
    .WIDTH(1)
  ) u_tx_clk_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i(gig_tx_clk_i),
    .sync_o(tx_clk_sync)
  );

  // Clock, valid, error and data share one synchroniser so that they stay aligned.
  mgr_sync #(
    .WIDTH(`MGR_RX_SYNC_W)
  ) u_rx_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i({gig_rx_clk_i, gig_rx_data_valid_i, gig_rx_error_in_i, gig_rx_byte_bus_i}),
    .sync_o(rx_sync)
  );

  wire rx_clk_s = rx_sync[`MGR_RX_SYNC_W-1];
  wire rx_dv_s = rx_sync[`MGR_RX_SYNC_W-2];
  wire rx_er_s = rx_sync[`MGR_RX_SYNC_W-3];
  wire [`MGR_BYTE_W-1:0] rx_byte_s = rx_sync[`MGR_BYTE_W-1:0];

  wire tx_rise = edge_seen(tx_clk_sync, tx_clk_last_reg);
  wire tx_fall = edge_seen(tx_clk_last_reg, tx_clk_sync);
  wire rx_rise = edge_seen(rx_clk_s, rx_clk_last_reg);

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_clk_last_reg <= 1'b0;
      rx_clk_last_reg <= 1'b0;
    end
    else
    begin
      tx_clk_last_reg <= tx_clk_sync;
      rx_clk_last_reg <= rx_clk_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit: one byte holding stage between client and link.

  reg hold_valid_reg;
  reg [`MGR_BYTE_W-1:0] hold_data_reg;
  reg hold_bad_reg;
  reg [`MGR_NIB_W-1:0] upper_nib_reg;
  reg fall_ctl_reg;

  wire accept = client_tx_valid_i & client_tx_ready_o;
  wire launch = tx_rise & hold_valid_reg;
  wire hold_valid_next = (hold_valid_reg & ~launch) | accept;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hold_valid_reg <= 1'b0;
      hold_data_reg <= `MGR_BYTE_RST;
      hold_bad_reg <= 1'b0;
      client_tx_ready_o <= 1'b0;
    end
    else
    begin
      hold_valid_reg <= hold_valid_next;
      client_tx_ready_o <= ~hold_valid_next;
      if (accept)
      begin
        hold_data_reg <= client_tx_data_i;
        // The client error counts only when it comes with the end of packet.
        hold_bad_reg <= client_tx_error_flag_i & client_tx_end_of_packet_i;
      end
    end
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gig_tx_byte_bus_o <= `MGR_BYTE_RST;
      gig_tx_frame_enable_o <= 1'b0;
      gig_tx_error_out_o <= 1'b0;
      rgmii_tx_nibble_o <= `MGR_NIB_RST;
      rgmii_tx_control_o <= 1'b0;
      upper_nib_reg <= `MGR_NIB_RST;
      fall_ctl_reg <= 1'b0;
    end
    else if (tx_rise)
    begin
      gig_tx_byte_bus_o <= hold_valid_reg ? hold_data_reg : `MGR_BYTE_RST;
      gig_tx_frame_enable_o <= hold_valid_reg;
      gig_tx_error_out_o <= hold_valid_reg & hold_bad_reg;
      rgmii_tx_nibble_o <= hold_valid_reg ?
        hold_data_reg[`MGR_LOW_NIB_LSB +: `MGR_NIB_W] : `MGR_NIB_RST;
      rgmii_tx_control_o <= hold_valid_reg;
      upper_nib_reg <= hold_valid_reg ?
        hold_data_reg[`MGR_UP_NIB_LSB +: `MGR_NIB_W] : `MGR_NIB_RST;
      fall_ctl_reg <= hold_valid_reg ^ (hold_valid_reg & hold_bad_reg);
    end
    else if (tx_fall)
    begin
      rgmii_tx_nibble_o <= upper_nib_reg;
      rgmii_tx_control_o <= fall_ctl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive: one byte of lag lets the last byte carry the end of packet.

  reg [1:0] rx_state_reg;
  reg [`MGR_BYTE_W-1:0] pend_data_reg;
  reg pend_first_reg;
  reg err_seen_reg;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_state_reg <= RX_IDLE;
      pend_data_reg <= `MGR_BYTE_RST;
      pend_first_reg <= 1'b0;
      err_seen_reg <= 1'b0;
      client_rx_valid_o <= 1'b0;
      client_rx_data_o <= `MGR_BYTE_RST;
      client_rx_sop_o <= 1'b0;
      client_rx_eop_o <= 1'b0;
      client_rx_error_o <= `MGR_RXERR_RST;
    end
    else
    begin
      client_rx_valid_o <= 1'b0;
      if (rx_rise)
      begin
        case (rx_state_reg)
          RX_IDLE:
          begin
            if (rx_dv_s)
            begin
              pend_data_reg <= rx_byte_s;
              pend_first_reg <= 1'b1;
              err_seen_reg <= rx_er_s;
              rx_state_reg <= RX_FRAME;
            end
          end
          RX_FRAME:
          begin
            client_rx_valid_o <= 1'b1;
            client_rx_data_o <= pend_data_reg;
            client_rx_sop_o <= pend_first_reg;
            client_rx_error_o <= `MGR_RXERR_RST;
            // valid falling marks the last byte
            if (rx_dv_s)
            begin
              client_rx_eop_o <= 1'b0;
              pend_data_reg <= rx_byte_s;
              pend_first_reg <= 1'b0;
              // error may come anywhere in the frame
              err_seen_reg <= err_seen_reg | rx_er_s;
            end
            else
            begin
              client_rx_eop_o <= 1'b1;
              client_rx_error_o[`MGR_RXERR_PHY_BIT] <= err_seen_reg;
              err_seen_reg <= 1'b0;
              rx_state_reg <= RX_IDLE;
            end
          end
          default:
          begin
            rx_state_reg <= RX_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/mgr_sync.v]
// Two flip-flop synchroniser for signals that enter from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none

module mgr_sync #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  // The first stage is read by the second stage only.
  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// [tb/mgr_phy_model.sv]
// Behavioural PHY that sends receive frames over the gigabit link.
`timescale 1ns/100ps
`default_nettype none

module mgr_phy_model (
  input wire logic clk_i,
  output logic rx_clk_o,
  output logic rx_dv_o,
  output logic rx_er_o,
  output logic [7:0] rx_byte_o
);
  logic [10:0] q[$];
  initial
  begin
    rx_clk_o = 0;
    rx_dv_o = 0;
    rx_er_o = 0;
    rx_byte_o = 8'hA5;
  end
  // The clock runs two idle periods past each frame so the last byte drains.
  // Pins move only just after clk rising edges so they never race the synchroniser.
  task automatic frame(input int n, input int epos);
    logic [7:0] b;
    for (int i = 0; i < n + 2; i++)
    begin
      b = (i < n) ? 8'($urandom) : ~rx_byte_o;
      rx_dv_o <= (i < n);
      rx_er_o <= (i == epos) || (i == n);
      rx_byte_o <= b;
      if (i < n)
        q.push_back({(i == n - 1) && (epos >= 0), i == n - 1, i == 0, b});
      repeat (4) @(posedge clk_i);
      rx_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      rx_clk_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb/mgr_phy_side_sva.sv]
// Checker for the PHY-side framing block.
`timescale 1ns/100ps
`default_nettype none

module mgr_phy_side_sva (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic client_tx_valid_i,
  input wire logic client_tx_ready_o,
  input wire logic [7:0] gig_tx_byte_bus_o,
  input wire logic gig_tx_frame_enable_o,
  input wire logic gig_tx_error_out_o,
  input wire logic [3:0] rgmii_tx_nibble_o,
  input wire logic rgmii_tx_control_o,
  input wire logic gig_tx_clk_i,
  input wire logic client_rx_valid_o,
  input wire logic client_rx_eop_o,
  input wire logic [5:0] client_rx_error_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_err_in_frame: assert property (gig_tx_error_out_o |-> gig_tx_frame_enable_o)
    else $error("tx error outside a frame");
  a_err_holds: assert property ($rose(gig_tx_error_out_o) |-> gig_tx_error_out_o[*6])
    else $error("tx error too short");
  a_ctl_in_frame: assert property (rgmii_tx_control_o |-> gig_tx_frame_enable_o)
    else $error("control high outside a frame");
  a_err_on_ctl: assert property ($rose(gig_tx_error_out_o) |->
    ##[2:7] (!rgmii_tx_control_o && gig_tx_frame_enable_o))
    else $error("error missing on control fall phase");
  a_tx_on_rise: assert property ($changed(gig_tx_byte_bus_o) |-> $past(gig_tx_clk_i, 2))
    else $error("tx byte changed away from a link rise");
  a_nib_low: assert property ($changed(gig_tx_byte_bus_o) && gig_tx_frame_enable_o
    |-> rgmii_tx_nibble_o == gig_tx_byte_bus_o[3:0])
    else $error("low nibble not sent with byte");
  a_nib_high: assert property ($changed(gig_tx_byte_bus_o) && gig_tx_frame_enable_o
    |-> ##[2:7] rgmii_tx_nibble_o == gig_tx_byte_bus_o[7:4])
    else $error("upper nibble not sent");
  a_rx_err_eop: assert property (client_rx_valid_o && client_rx_error_o[0] |-> client_rx_eop_o)
    else $error("rx error outside last byte");
  a_rx_pulse: assert property (client_rx_valid_o |=> !client_rx_valid_o)
    else $error("rx valid longer than one cycle");
  c_tx_err: cover property ($rose(gig_tx_error_out_o));
  c_rx_err: cover property (client_rx_valid_o && client_rx_error_o[0]);
  c_taken: cover property (client_tx_valid_i && client_tx_ready_o);
endmodule

bind mgr_phy_side mgr_phy_side_sva chk_u (.clk_i, .arst_n_i, .client_tx_valid_i,
  .client_tx_ready_o, .gig_tx_byte_bus_o, .gig_tx_frame_enable_o, .gig_tx_error_out_o,
  .rgmii_tx_nibble_o, .rgmii_tx_control_o, .gig_tx_clk_i, .client_rx_valid_o,
  .client_rx_eop_o, .client_rx_error_o);
`default_nettype wire

// [tb/tb_mgr_phy_side.sv]
// Self-checking bench for the PHY-side framing block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end

module tb_mgr_phy_side;
  logic clk_i = 0, arst_n_i = 0, tx_clk = 0, tx_v = 0, tx_eop = 0, tx_err = 0;
  logic [7:0] tx_d = 8'h00;
  wire rx_clk, rx_dv, rx_er, rdy, en, terr, ctl, rv, sop, eop;
  wire [7:0] rx_d, tbyte, rd;
  wire [3:0] nib;
  wire [5:0] re;
  int err_count = 0, compares = 0, cyc = 0;
  logic [8:0] tq[$];
  logic [8:0] t;
  logic [8:0] t2;
  logic [2:0] tdiv = 3'h0;
  logic [10:0] r;

  mgr_phy_model phy_u (.clk_i(clk_i), .rx_clk_o(rx_clk), .rx_dv_o(rx_dv), .rx_er_o(rx_er),
    .rx_byte_o(rx_d));
  mgr_phy_side dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .gig_tx_clk_i(tx_clk),
    .client_tx_valid_i(tx_v), .client_tx_data_i(tx_d), .client_tx_end_of_packet_i(tx_eop),
    .client_tx_error_flag_i(tx_err), .client_tx_ready_o(rdy), .gig_tx_byte_bus_o(tbyte),
    .gig_tx_frame_enable_o(en), .gig_tx_error_out_o(terr), .rgmii_tx_nibble_o(nib),
    .rgmii_tx_control_o(ctl), .gig_rx_clk_i(rx_clk), .gig_rx_data_valid_i(rx_dv),
    .gig_rx_error_in_i(rx_er), .gig_rx_byte_bus_i(rx_d), .client_rx_valid_o(rv),
    .client_rx_data_o(rd), .client_rx_sop_o(sop), .client_rx_eop_o(eop),
    .client_rx_error_o(re));

  initial forever #10 clk_i = ~clk_i;
  // The link clock toggles every four clk cycles, giving a 160 ns period.
  always @(posedge clk_i)
  begin
    tdiv <= tdiv + 3'h1;
    tx_clk <= tdiv[2];
  end

  task automatic close_out();
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // The error flag is random on inner bytes, where it must be ignored.
  task automatic send(input int n, input logic e);
    for (int i = 0; i < n; i++)
    begin
      tx_v <= 1;
      tx_d <= 8'($urandom);
      tx_eop <= (i == n - 1);
      tx_err <= (i == n - 1) ? e : 1'($urandom);
      do @(posedge clk_i); while (rdy !== 1'b1);
      tq.push_back({(i == n - 1) && e, tx_d});
    end
    tx_v <= 0;
    repeat (40) @(posedge clk_i);
  endtask

  always @(posedge tx_clk)
    if (arst_n_i && en !== 1'b0)
    begin
      t = tq.size() ? tq.pop_front() : 9'h1FF;
      `CHK("tx_byte", t[7:0], tbyte)
      `CHK("tx_err", t[8], terr)
      `CHK("tx_nib_hi", t[7:4], nib)
      `CHK("tx_ctl_fall", !t[8], ctl)
    end

  // Half a link period after a link rise, one clk cycle after the launch, the low nibble and a high control stand.
  always @(negedge tx_clk)
    if (arst_n_i && en !== 1'b0)
    begin
      t2 = tq.size() ? tq[0] : 9'h1FF;
      `CHK("tx_nib_lo", t2[3:0], nib)
      `CHK("tx_ctl_rise", 1'b1, ctl)
    end

  always @(negedge clk_i)
    if (rv === 1'b1)
    begin
      r = phy_u.q.size() ? phy_u.q.pop_front() : 11'h7FF;
      `CHK("rx_data", r[7:0], rd)
      `CHK("rx_sop", r[8], sop)
      `CHK("rx_eop", r[9], eop)
      `CHK("rx_err", {5'h00, r[10]}, re)
    end

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  initial
  begin
    void'($urandom(32'hF35E));
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1;
    repeat (3) @(posedge clk_i);
    fork
      begin
        send(1, 1);
        send(5, 0);
        send(2, 1);
        send(4, 0);
      end
      begin
        phy_u.frame(4, 2);
        phy_u.frame(3, -1);
        repeat (15) @(posedge clk_i);
        phy_u.frame(1, 0);
      end
    join
    repeat (20) @(posedge clk_i);
    `CHK("tx_left", 0, tq.size())
    `CHK("rx_left", 0, phy_u.q.size())
    close_out();
  end
endmodule
`default_nettype wire
